// ==== design/sram_ctl_defines.vh ====
/*
 Constants for the asynchronous SRAM host controller: pin widths, timing figures in ns
 and their cycle counts at the 10 MHz system clock.
 Assumes a 64K x 16 static RAM with active-low select, output enable, write enable and byte enables.
*/
`ifndef SRAM_CTL_DEFINES_VH
`define SRAM_CTL_DEFINES_VH
`define ADDR_W 16
`define DATA_W 16
`define CLK_PERIOD_NS 100
`define T_READ_CYCLE_NS 20
`define T_ADDR_TO_END_NS 12
`define T_DATA_SETUP_NS 10
`define T_WRITE_FLOAT_NS 8
`define T_DESELECT_FLOAT_NS 8
`define T_ACCESS_NS 20
// Cycles from a settled data pin to the synchroniser output, agreement included.
`define SYNC_LAT_CYC 4
`define CDIV_UP(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 4
`endif

// ==== design/sram_host_ctl.v ====
/*
 Host controller for a 64K x 16 asynchronous static RAM. A user request (read or write,
 word or byte) is turned into a sequence of pin levels held for whole clock cycles.
 Assumes a 10 MHz clock, so each nanosecond timing figure rounds to one or more cycles,
 and that the RAM data bus is resolved from o_dq_out and o_dq_oe outside this module.
*/
`timescale 1ns/100ps
`include "sram_ctl_defines.vh"
module sram_host_ctl #(
	parameter AW = `ADDR_W,
	parameter DW = `DATA_W
) (
	input wire i_clk,
	input wire i_rst,
	input wire i_req,
	input wire i_we,
	input wire [1:0] i_be,
	input wire [AW-1:0] i_addr,
	input wire [DW-1:0] i_wdata,
	output wire o_ready,
	output reg o_rvalid,
	output reg [DW-1:0] o_rdata,
	output reg [AW-1:0] o_sram_addr,
	output reg o_cs_n,
	output reg o_oe_n,
	output reg o_we_n,
	output reg o_low_byte_enable_n,
	output reg o_high_byte_enable_n,
	output reg [DW-1:0] o_dq_out,
	output reg o_dq_oe,
	input wire [DW-1:0] i_dq_in
);
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_RD = 3'h1;
	localparam [2:0] ST_RD_SAMPLE = 3'h2;
	localparam [2:0] ST_WR_SETUP = 3'h3;
	localparam [2:0] ST_WR_PULSE = 3'h4;
	localparam [2:0] ST_RECOVER = 3'h5;
	// Read strobes stay low long enough for access time plus three sync stages and agreement.
	localparam integer RD_CYC_I = `CDIV_UP(`T_ACCESS_NS) + `SYNC_LAT_CYC;
	// Output enable is high in writes, so this pulse length is more than the bare minimum needs.
	localparam integer WP_CYC_I = `CDIV_UP(`T_WRITE_FLOAT_NS + `T_DATA_SETUP_NS);
	localparam integer REC_CYC_I = `CDIV_UP(`T_DESELECT_FLOAT_NS);
	localparam [`CNT_W-1:0] RD_CYC = RD_CYC_I[`CNT_W-1:0];
	localparam [`CNT_W-1:0] WP_CYC = WP_CYC_I[`CNT_W-1:0];
	localparam [`CNT_W-1:0] REC_CYC = REC_CYC_I[`CNT_W-1:0];
	localparam [`CNT_W-1:0] ONE = {{(`CNT_W-1){1'b0}}, 1'b1};
	localparam [1:0] LANES_OFF = 2'h3;

	reg [2:0] state_q;
	reg [2:0] state_d;
	reg [`CNT_W-1:0] cnt_q;
	reg [`CNT_W-1:0] cnt_d;
	reg rvalid_d;
	reg [DW-1:0] rdata_d;
	reg [AW-1:0] addr_d;
	reg cs_n_d;
	reg oe_n_d;
	reg we_n_d;
	reg [1:0] lane_n_d;
	reg [DW-1:0] dq_out_d;
	reg dq_oe_d;
	wire [DW-1:0] dq_sync;
	wire [1:0] lane_on;
	wire take;

	sram_pin_sync #(.W(DW)) u_sync (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_pin(i_dq_in),
		.o_val(dq_sync)
	);

	// Reads are spaced by the recovery state, which also covers the cycle-time floor.
	assign o_ready = (state_q == ST_IDLE);
	// Requests with no byte enabled are dropped here rather than run as empty accesses.
	assign take = i_req && (i_be != 2'h0);
	// Lanes selected for the current access, used to zero the unselected half of a read.
	assign lane_on = ~{o_high_byte_enable_n, o_low_byte_enable_n};

	function [DW-1:0] lane_mask;
		input [1:0] be;
		begin
			lane_mask = {{(DW/2){be[1]}}, {(DW/2){be[0]}}};
		end
	endfunction

	// Every next value but rvalid_d defaults to its register, so a waiting state holds all pins still.
	always @* begin
		state_d = state_q;
		cnt_d = cnt_q;
		rvalid_d = 1'b0;
		rdata_d = o_rdata;
		addr_d = o_sram_addr;
		cs_n_d = o_cs_n;
		oe_n_d = o_oe_n;
		we_n_d = o_we_n;
		lane_n_d = {o_high_byte_enable_n, o_low_byte_enable_n};
		dq_out_d = o_dq_out;
		dq_oe_d = o_dq_oe;
		case (state_q)
			ST_IDLE: begin
				if (take) begin
					// Address is placed with or before every strobe.
					addr_d = i_addr;
					cs_n_d = 1'b0;
					we_n_d = 1'b1;
					lane_n_d = ~i_be;
					if (i_we) begin
						// Output enable stays high so the RAM never drives during the write.
						oe_n_d = 1'b1;
						dq_out_d = i_wdata & lane_mask(i_be);
						dq_oe_d = 1'b1;
						state_d = ST_WR_SETUP;
					end else begin
						oe_n_d = 1'b0;
						dq_oe_d = 1'b0;
						cnt_d = RD_CYC;
						state_d = ST_RD;
					end
				end
			end

			ST_RD: begin
				// The count covers the RAM settling and the data passing the synchroniser.
				cnt_d = cnt_q - ONE;
				if (cnt_q == ONE) begin
					state_d = ST_RD_SAMPLE;
				end
			end

			ST_RD_SAMPLE: begin
				rdata_d = dq_sync & lane_mask(lane_on);
				rvalid_d = 1'b1;
				cs_n_d = 1'b1;
				oe_n_d = 1'b1;
				lane_n_d = LANES_OFF;
				cnt_d = REC_CYC;
				state_d = ST_RECOVER;
			end

			ST_WR_SETUP: begin
				// Select and byte enables were low a cycle before write enable falls.
				we_n_d = 1'b0;
				cnt_d = WP_CYC;
				state_d = ST_WR_PULSE;
			end

			ST_WR_PULSE: begin
				cnt_d = cnt_q - ONE;
				if (cnt_q == ONE) begin
					// Write enable rises first; address, select, bytes and data stay put one more cycle.
					we_n_d = 1'b1;
					cnt_d = REC_CYC;
					state_d = ST_RECOVER;
				end
			end

			ST_RECOVER: begin
				// After a write, write enable rose a cycle earlier, so select and lanes may now be released.
				cs_n_d = 1'b1;
				lane_n_d = LANES_OFF;
				dq_oe_d = 1'b0;
				cnt_d = cnt_q - ONE;
				if (cnt_q <= ONE) begin
					state_d = ST_IDLE;
				end
			end

			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// Sequencer state and its cycle count.
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_q <= ST_IDLE;
			cnt_q <= {`CNT_W{1'b0}};
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	// Pins come straight from flip-flops so the RAM never sees a glitch on a strobe.
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_sram_addr <= {AW{1'b0}};
			o_cs_n <= 1'b1;
			o_oe_n <= 1'b1;
			o_we_n <= 1'b1;
			o_low_byte_enable_n <= 1'b1;
			o_high_byte_enable_n <= 1'b1;
			o_dq_out <= {DW{1'b0}};
			o_dq_oe <= 1'b0;
		end else begin
			o_sram_addr <= addr_d;
			o_cs_n <= cs_n_d;
			o_oe_n <= oe_n_d;
			o_we_n <= we_n_d;
			o_low_byte_enable_n <= lane_n_d[0];
			o_high_byte_enable_n <= lane_n_d[1];
			o_dq_out <= dq_out_d;
			o_dq_oe <= dq_oe_d;
		end
	end

	// Read result: the data word stays until the next read, the strobe lasts one cycle.
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rvalid <= 1'b0;
			o_rdata <= {DW{1'b0}};
		end else begin
			o_rvalid <= rvalid_d;
			o_rdata <= rdata_d;
		end
	end
endmodule // sram_host_ctl

// ==== design/sram_pin_sync.v ====
/*
 Three-stage synchroniser for the data pins read back from the RAM; a bit changes
 once the second and third stages agree.
 Assumes the pin may change at any time relative to i_clk.
*/
`timescale 1ns/100ps
`include "sram_ctl_defines.vh"
module sram_pin_sync #(
	parameter W = `DATA_W
) (
	input wire i_clk,
	input wire i_rst,
	input wire [W-1:0] i_pin,
	output reg [W-1:0] o_val
);
	reg [W-1:0] s1_q;
	reg [W-1:0] s2_q;
	reg [W-1:0] s3_q;
	wire [W-1:0] agree = ~(s2_q ^ s3_q);
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s1_q <= {W{1'b0}};
			s2_q <= {W{1'b0}};
			s3_q <= {W{1'b0}};
			o_val <= {W{1'b0}};
		end else begin
			s1_q <= i_pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			// Each bit moves on its own once stages two and three agree on it.
			o_val <= (o_val & ~agree) | (s3_q & agree);
		end
	end
endmodule // sram_pin_sync

// ==== verification/async_sram_word_byte_access_tb_top.sv ====
/* Bench: random word and byte traffic through the controller to a RAM model.
 Assumes the design, model and checker are compiled first. */
`timescale 1ns/100ps
module async_sram_word_byte_access_tb_top;
logic clk, rst, req, we, ready, rvalid, cs_n, oe_n, we_n, lbe_n, hbe_n, doe;
logic [1:0] be;
logic [15:0] addr, wd, rdata, sa, dout, mq, sh [0:7];
logic [15:0] q [$];
int miscompares, num_checks;
wire [15:0] bus = doe ? dout : mq;
sram_host_ctl DUT (.i_clk(clk), .i_rst(rst), .i_req(req), .i_we(we), .i_be(be), .i_addr(addr), .i_wdata(wd),
	.o_ready(ready), .o_rvalid(rvalid), .o_rdata(rdata), .o_sram_addr(sa), .o_cs_n(cs_n), .o_oe_n(oe_n),
	.o_we_n(we_n), .o_low_byte_enable_n(lbe_n), .o_high_byte_enable_n(hbe_n), .o_dq_out(dout),
	.o_dq_oe(doe), .i_dq_in(bus));
sram_model ram (.i_a(sa), .i_d(bus), .i_cs_n(cs_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_lb_n(lbe_n),
	.i_hb_n(hbe_n), .o_q(mq));
task chk(input logic [15:0] e, s);
	num_checks++;
	if (e !== s) begin
		miscompares++;
		$display("BAD rdata exp %h got %h", e, s);
	end
endtask
task chk_left(input logic [15:0] e, s);
	num_checks++;
	if (e !== s) begin
		miscompares++;
		$display("BAD pending reads exp %0d got %0d", e, s);
	end
endtask
task test_done;
	$display("checks %0d miscompares %0d", num_checks, miscompares);
	if (miscompares == 0 && num_checks > 0)
		$display("Finished cleanly");
	else
		$display("Finished with errors");
	$finish;
endtask
task op(input logic w, input logic [1:0] b, input logic [2:0] a, input logic [15:0] d);
	@(negedge clk);
	while (ready !== 1'b1) @(negedge clk);
	@(posedge clk);
	req <= 1'b1;
	we <= w;
	be <= b;
	addr <= {a, 13'h0b5d};
	wd <= d;
	@(posedge clk);
	req <= 1'b0;
	if (b[0] && w) sh[a][7:0] = d[7:0];
	if (b[1] && w) sh[a][15:8] = d[15:8];
	if (b != 2'h0 && !w) q.push_back({b[1] ? sh[a][15:8] : 8'h00, b[0] ? sh[a][7:0] : 8'h00});
endtask
always @(negedge clk) if (rvalid === 1'b1) chk(q.size() ? q.pop_front() : 16'hxxxx, rdata);
initial begin
	clk = 1'b0;
	forever #50 clk = ~clk;
end
initial begin
	rst = 1'b1;
	req = 1'b0;
	we = 1'b0;
	be = 2'h0;
	addr = 16'h0;
	wd = 16'h0;
	repeat (2) @(posedge clk);
	rst <= 1'b0;
	void'($urandom(32'h48ee55a0));
	for (int i = 0; i < 8; i++) op(1'b1, 2'h3, i[2:0], 16'($urandom));
	for (int i = 0; i < 60; i++) op(1'($urandom), 2'($urandom), 3'($urandom), 16'($urandom));
	repeat (12) @(posedge clk);
	chk_left(16'h0, 16'(q.size()));
	test_done;
end
initial begin
	#1000000;
	miscompares++;
	test_done;
end
endmodule // async_sram_word_byte_access_tb_top

// ==== verification/sram_host_ctl_sva.sv ====
/* Pin checker for the SRAM host controller.
 Assumes it is bound into sram_host_ctl. */
`timescale 1ns/100ps
module sram_host_ctl_sva (
	input logic i_clk, i_rst, i_req, o_ready, o_cs_n, o_oe_n, o_we_n, o_dq_oe,
	input logic o_low_byte_enable_n, o_high_byte_enable_n,
	input logic [1:0] i_be,
	input logic [15:0] i_addr, o_sram_addr, o_dq_out
);
default clocking @(posedge i_clk); endclocking
default disable iff (i_rst);
rd_we_high_a: assert property (!o_oe_n |-> o_we_n)
	else $error("we low in read");
bus_turn_a: assert property (o_dq_oe |-> o_oe_n)
	else $error("bus contention");
take_addr_a: assert property (i_req && o_ready && i_be != 2'h0 |=> !o_cs_n && o_sram_addr == $past(i_addr))
	else $error("address not set");
cs_lead_a: assert property ($rose(o_we_n) |-> $past(o_cs_n, 2) == 1'b0)
	else $error("select late");
addr_hold_a: assert property (!o_we_n |=> $stable(o_sram_addr))
	else $error("address moved");
data_setup_a: assert property (!o_we_n |-> o_dq_oe && $stable(o_dq_out))
	else $error("data unstable");
we_pulse_a: assert property ($fell(o_we_n) |-> o_oe_n ##1 o_we_n && o_oe_n)
	else $error("bad write pulse");
be_lead_a: assert property ($rose(o_we_n) |-> $past(o_low_byte_enable_n, 2) == 1'b0 || $past(o_high_byte_enable_n, 2) == 1'b0)
	else $error("byte enable late");
read_len_a: assert property ($fell(o_oe_n) |=> !o_oe_n [*5] ##1 o_oe_n)
	else $error("bad read length");
endmodule // sram_host_ctl_sva
bind sram_host_ctl sram_host_ctl_sva chk (.i_clk, .i_rst, .i_req, .o_ready, .o_cs_n, .o_oe_n, .o_we_n,
	.o_dq_oe, .o_low_byte_enable_n, .o_high_byte_enable_n, .i_be, .i_addr, .o_sram_addr, .o_dq_out);

// ==== verification/sram_model.sv ====
/* Behavioural 64K x 16 asynchronous RAM.
 Assumes the bench resolves the data bus. */
`timescale 1ns/100ps
module sram_model (
	input wire [15:0] i_a, i_d,
	input wire i_cs_n, i_oe_n, i_we_n, i_lb_n, i_hb_n,
	output wire [15:0] o_q
);
reg [15:0] m [0:65535];
wire rd = !i_cs_n && !i_oe_n && i_we_n;
// Idle lanes show inverted data, so a controller that samples them cannot pass by luck.
assign #10 o_q = {rd && !i_hb_n ? m[i_a][15:8] : ~m[i_a][15:8],
	rd && !i_lb_n ? m[i_a][7:0] : ~m[i_a][7:0]};
always @(posedge i_we_n) if (!i_cs_n) begin
	if (!i_lb_n) m[i_a][7:0] <= i_d[7:0];
	if (!i_hb_n) m[i_a][15:8] <= i_d[15:8];
end
endmodule // sram_model
